// ===== shared/cba_pkg.sv
// Package of types and constants for the bus address-phase block.
package cba_pkg;
	localparam int CBA_ADDR_MSB   = 31;
	localparam int CBA_ADDR_LSB   = 3;
	localparam int CBA_PAR_LSB    = 5;
	localparam int CBA_A20_BIT    = 20;
	localparam int CBA_ADDR_W     = CBA_ADDR_MSB - CBA_ADDR_LSB + 1;
	localparam int CBA_PAR_W      = CBA_ADDR_MSB - CBA_PAR_LSB + 1;
	localparam int CBA_PAR_OFS    = CBA_PAR_LSB - CBA_ADDR_LSB;

	// Reset levels of the outputs.
	localparam logic CBA_STROBE_RST = 1'h1;
	localparam logic CBA_ERR_RST    = 1'h1;
	localparam logic CBA_OE_RST     = 1'h1;

	// Kind of a requested bus cycle.
	typedef enum logic [1:0] {
		CBA_KIND_MEM,
		CBA_KIND_IO,
		CBA_KIND_SPECIAL
	} cba_kind_t;

	// Request from the core to start a bus cycle.
	typedef struct packed {
		cba_kind_t                 kind;
		logic [CBA_ADDR_MSB:0]     addr;
		logic [CBA_ADDR_W-1:0]     special_code;
	} cba_req_t;

	// Snoop address delivered to the cache side.
	typedef struct packed {
		logic                      valid;
		logic [CBA_ADDR_MSB:0]     addr;
	} cba_snoop_t;

	// Even parity over the cache-line address bits.
	function automatic logic cba_even_par(
		input logic [CBA_PAR_W-1:0] bits
	);
		cba_even_par = ^bits;
	endfunction : cba_even_par
endpackage : cba_pkg

// ===== src/cba_parity_chk.sv
// Registered address parity checker for inquire cycles.
`timescale 1ns/1ns
`default_nettype none
module cba_parity_chk (
	input  wire logic                          clk_in,     // Bus clock.
	input  wire logic                          rst_b_in,   // Async reset, low.
	input  wire logic                          check_in,   // Sample this cycle.
	input  wire logic [cba_pkg::CBA_PAR_W-1:0] addr_in,    // Bits 31 to 5.
	input  wire logic                          par_in,     // Parity pin.
	output logic                               err_n_out   // Error, one clock.
);
	import cba_pkg::*;

	logic err_n_d;
	logic err_n_q;

	// -------------------------------------------------------------
	// Check logic
	// -------------------------------------------------------------
	always_comb begin
		err_n_d = 1'h1;
		if (check_in && (cba_even_par(addr_in) != par_in)) begin
			err_n_d = 1'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			err_n_q <= CBA_ERR_RST;
		end else begin
			err_n_q <= err_n_d;
		end
	end

	assign err_n_out = err_n_q;
endmodule : cba_parity_chk
`default_nettype wire

// ===== src/cba_addr_phase.sv
// Address phase of the processor external bus with inquire support.
//
// Functional notes
// - Mask address bit 20 when requested.
// - Drive address bits 31:3 for memory/IO.
// - Special cycles carry cycle code on address.
// - System drives 31:5 in inquire; device samples.
// - Strobe low marks each cycle start.
// - Address and strobe from same edge.
// - Strobe copy identical to strobe.
// - Float address and parity on hold edge.
// - Other outputs stay driven under hold.
// - Even parity over bits 31:5 and parity.
// - Bits 4 and 3 excluded from parity.
// - Parity mismatch pulses error one clock.
`timescale 1ns/1ns
`default_nettype none
module cba_addr_phase (
	input  wire logic                          clk_in,          // Bus clock.
	input  wire logic                          rst_b_in,        // Reset, low.
	input  wire logic                          addr20_mask_in,  // Mask bit 20.
	input  wire logic                          req_valid_in,    // Start cycle.
	input  wire cba_pkg::cba_req_t             req_in,          // Cycle request.
	output logic                               req_ready_out,   // Can start.
	input  wire logic                          addr_hold_req,   // Hold request.
	input  wire logic                          inq_valid_in,    // Inquire strobe.
	input  wire logic [cba_pkg::CBA_ADDR_W-1:0] addr_bus_in,    // Pin level.
	output logic [cba_pkg::CBA_ADDR_W-1:0]     addr_bus_out,    // Pin drive.
	output logic                               addr_hi_oe_out,  // Bits 31:5 oe.
	output logic                               addr_lo_oe_out,  // Bits 4:3 oe.
	input  wire logic                          addr_parity_in,  // Parity pin.
	output logic                               addr_parity_bit, // Parity drive.
	output logic                               addr_parity_oe_out, // Parity oe.
	output logic                               cycle_strobe_n,  // Cycle start.
	output logic                               cycle_strobe_copy_n, // Copy.
	output logic                               addr_parity_err_n, // Bad parity.
	output cba_pkg::cba_snoop_t                snoop_out        // Snoop addr.
);
	import cba_pkg::*;

	typedef enum logic [1:0] {
		CBA_ST_IDLE,
		CBA_ST_HOLD,
		CBA_ST_RESUME
	} cba_state_t;

	// -------------------------------------------------------------
	// Elaboration checks and state
	// -------------------------------------------------------------
	// The parity field must sit above bits 4:3, bit 20 inside the pins.
	if (CBA_PAR_LSB <= CBA_ADDR_LSB || CBA_A20_BIT > CBA_ADDR_MSB ||
		CBA_A20_BIT < CBA_ADDR_LSB) begin : g_bad_layout
		$error("Address pin layout not supported.");
	end

	// Bus-cycle and hold state.
	cba_state_t                state_q;
	cba_state_t                state_d;
	// Registered pin drive.
	logic [CBA_ADDR_W-1:0]     addr_q;
	logic [CBA_ADDR_W-1:0]     addr_d;
	logic                      par_q;
	logic                      par_d;
	logic                      oe_q;
	logic                      oe_d;
	logic                      strobe_n_q;
	logic                      strobe_n_d;
	logic                      strobe_c_n_q;
	logic                      strobe_c_n_d;
	// Core handshake and snoop result.
	logic                      ready_q;
	logic                      ready_d;
	cba_snoop_t                snoop_q;
	cba_snoop_t                snoop_d;
	// Combinational address path.
	logic [CBA_ADDR_MSB:0]     phys;
	logic [CBA_ADDR_W-1:0]     drive_val;
	logic                      inq_sample;

	// -------------------------------------------------------------
	// Address formation
	// -------------------------------------------------------------
	always_comb begin
		// Bit 20 is masked before anything else sees the address.
		phys = req_in.addr;
		if (addr20_mask_in) begin
			phys[CBA_A20_BIT] = 1'h0;
		end
		drive_val = phys[CBA_ADDR_MSB:CBA_ADDR_LSB];
		// Special cycles ignore the mask: the code is not an address.
		// special cycle code
		if (req_in.kind == CBA_KIND_SPECIAL) begin
			drive_val = req_in.special_code;
		end
	end

	// Only an address seen while our drivers are off is the system's.
	// sample snoop address
	assign inq_sample = (state_q == CBA_ST_HOLD) && inq_valid_in;

	// -------------------------------------------------------------
	// Cycle and hold control
	// -------------------------------------------------------------
	always_comb begin
		state_d      = state_q;
		addr_d       = addr_q;
		par_d        = par_q;
		oe_d         = oe_q;
		strobe_n_d   = 1'h1;
		ready_d      = 1'h0;
		snoop_d      = '{valid: 1'h0, addr: snoop_q.addr};
		unique case (state_q)
			CBA_ST_IDLE: begin
				// Ready is registered: a request is taken the edge after.
				ready_d = !addr_hold_req;
				// Hold wins over a pending request, so the pins are never
				// driven by both sides at once.
				// system requests hold
				if (addr_hold_req) begin
					oe_d    = 1'h0;
					state_d = CBA_ST_HOLD;
				end else if (req_valid_in && ready_q) begin
					addr_d     = drive_val;
					// Parity comes from the value being registered, so the
					// pins and the parity bit change on one edge.
					// bits 4:3 excluded
					par_d      = cba_even_par(
						drive_val[CBA_ADDR_W-1:CBA_PAR_OFS]);
					strobe_n_d = 1'h0;
				end
			end
			CBA_ST_HOLD: begin
				// A line is 32 bytes, so snoop bits 4:0 read as zero.
				if (inq_sample) begin
					snoop_d.valid = 1'h1;
					snoop_d.addr  = {addr_bus_in[CBA_ADDR_W-1:CBA_PAR_OFS],
						{CBA_PAR_LSB{1'h0}}};
				end
				// Hold is a level; drivers return the edge after it drops.
				// redrive before next cycle
				if (!addr_hold_req) begin
					oe_d    = 1'h1;
					state_d = CBA_ST_RESUME;
				end
			end
			CBA_ST_RESUME: begin
				// The cycle after hold only redrives the pins, so the
				// address is settled before the next strobe.
				ready_d = !addr_hold_req;
				state_d = CBA_ST_IDLE;
				if (addr_hold_req) begin
					oe_d    = 1'h0;
					state_d = CBA_ST_HOLD;
				end
			end
		endcase
		// The copy is a register of its own so each pin has one load.
		// copy follows strobe
		strobe_c_n_d = strobe_n_d;
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q      <= CBA_ST_IDLE;
			addr_q       <= '0;
			par_q        <= 1'h0;
			oe_q         <= CBA_OE_RST;
			strobe_n_q   <= CBA_STROBE_RST;
			strobe_c_n_q <= CBA_STROBE_RST;
			ready_q      <= 1'h0;
			snoop_q      <= '0;
		end else begin
			state_q      <= state_d;
			addr_q       <= addr_d;
			par_q        <= par_d;
			oe_q         <= oe_d;
			strobe_n_q   <= strobe_n_d;
			strobe_c_n_q <= strobe_c_n_d;
			ready_q      <= ready_d;
			snoop_q      <= snoop_d;
		end
	end

	// -------------------------------------------------------------
	// Inquire parity check
	// -------------------------------------------------------------
	// check sampled inquire
	cba_parity_chk cba_parity_chk_inst (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.check_in  (inq_sample),
		.addr_in   (addr_bus_in[CBA_ADDR_W-1:CBA_PAR_OFS]),
		.par_in    (addr_parity_in),
		.err_n_out (addr_parity_err_n)
	);

	// -------------------------------------------------------------
	// Output pins
	// -------------------------------------------------------------
	assign addr_bus_out        = addr_q;
	assign addr_hi_oe_out      = oe_q;
	assign addr_lo_oe_out      = oe_q;
	assign addr_parity_bit     = par_q;
	assign addr_parity_oe_out  = oe_q;
	// strobes stay driven
	// The strobes have no enable, so a hold never floats them.
	assign cycle_strobe_n      = strobe_n_q;
	assign cycle_strobe_copy_n = strobe_c_n_q;
	assign req_ready_out       = ready_q;
	assign snoop_out           = snoop_q;
endmodule : cba_addr_phase
`default_nettype wire

// ===== tb/cba_addr_phase_props.sv
// Checker of the bus address-phase block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module cba_addr_phase_props (
	input wire logic              clk_in,
	input wire logic              rst_b_in,
	input wire logic              addr20_mask_in,
	input wire logic              req_valid_in,
	input wire cba_pkg::cba_req_t req_in,
	input wire logic              req_ready_out,
	input wire logic              addr_hold_req,
	input wire logic              inq_valid_in,
	input wire logic [28:0]       addr_bus_in,
	input wire logic [28:0]       addr_bus_out,
	input wire logic              addr_hi_oe_out,
	input wire logic              addr_parity_in,
	input wire logic              addr_parity_bit,
	input wire logic              addr_parity_oe_out,
	input wire logic              cycle_strobe_n,
	input wire logic              cycle_strobe_copy_n,
	input wire logic              addr_parity_err_n,
	input wire cba_pkg::cba_snoop_t snoop_out
);
	import cba_pkg::*;
	logic [28:0] exp_a;
	assign exp_a = {req_in.addr[31:21], req_in.addr[20] & !addr20_mask_in,
		req_in.addr[19:3]};
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_take;
		req_valid_in && req_ready_out && !addr_hold_req;
	endsequence
	sequence s_inq;
		inq_valid_in && !addr_hi_oe_out;
	endsequence
	sequence s_mem_take;
		s_take and (req_in.kind != CBA_KIND_SPECIAL);
	endsequence
	sequence s_spc_take;
		s_take and (req_in.kind == CBA_KIND_SPECIAL);
	endsequence
	// A further take in the strobe cycle keeps the strobe low.
	sequence s_pulse;
		!cycle_strobe_n ##1 (cycle_strobe_n ||
			$past(req_valid_in && req_ready_out && !addr_hold_req));
	endsequence
	chk_strobe_start: assert property (
		s_take |=> s_pulse)
		else $error("Strobe not one pulse after a request.");
	chk_strobe_cause: assert property (
		!cycle_strobe_n |-> $past(req_valid_in && req_ready_out &&
			!addr_hold_req))
		else $error("Strobe without a taken request.");
	chk_copy_same: assert property (
		cycle_strobe_copy_n == cycle_strobe_n)
		else $error("Strobe copy differs.");
	chk_addr_mem: assert property (
		s_mem_take |=> addr_bus_out == $past(exp_a) && !cycle_strobe_n)
		else $error("Cycle address wrong.");
	chk_special_code: assert property (
		s_spc_take |=> addr_bus_out == $past(req_in.special_code))
		else $error("Special code wrong.");
	chk_out_parity: assert property (
		!cycle_strobe_n |-> addr_hi_oe_out && addr_parity_oe_out &&
			addr_parity_bit == ^addr_bus_out[28:2])
		else $error("Driven parity wrong.");
	chk_hold_float: assert property (
		addr_hold_req |=> !addr_hi_oe_out && !addr_parity_oe_out &&
			!req_ready_out)
		else $error("Address not floated under hold.");
	chk_inq_check: assert property (
		s_inq |=> snoop_out.valid && addr_parity_err_n ==
			!$past(^{addr_bus_in[28:2], addr_parity_in}))
		else $error("Inquire parity check wrong.");
	chk_err_cause: assert property (
		!addr_parity_err_n |-> $past(inq_valid_in && !addr_hi_oe_out))
		else $error("Parity error without inquire.");
	chk_hold_release: assert property (
		$fell(addr_hold_req) |=> addr_hi_oe_out && addr_parity_oe_out)
		else $error("Address not redriven.");
endmodule : cba_addr_phase_props
bind cba_addr_phase cba_addr_phase_props cba_addr_phase_props_inst (.*);
`default_nettype wire

// ===== tb/cba_sys_model.sv
// Model of the system bus controller that runs inquire cycles.
`timescale 1ns/1ns
`default_nettype none
module cba_sys_model (
	input  wire logic        clk_in,        // Bus clock.
	input  wire logic        cmd_hold_in,   // Ask for the address bus.
	input  wire logic        cmd_inq_in,    // Run one inquire.
	input  wire logic [31:0] cmd_addr_in,   // Inquire address.
	input  wire logic        cmd_bad_in,    // Send wrong parity.
	input  wire logic [28:0] dev_addr_in,   // Device drive.
	input  wire logic        dev_hi_oe_in,  // Device drives 31:5.
	input  wire logic        dev_lo_oe_in,  // Device drives 4:3.
	input  wire logic        dev_par_in,    // Device parity.
	input  wire logic        dev_par_oe_in, // Device drives parity.
	output logic             hold_out,      // Hold request.
	output logic             inq_out,       // Inquire valid.
	output logic [28:0]      bus_out,       // Resolved address pins.
	output logic             par_out        // Resolved parity pin.
);
	logic [29:0] last_q;
	logic        drv;
	// hold first, address only once the device has let go.
	assign hold_out = cmd_hold_in;
	assign drv = cmd_hold_in && !dev_hi_oe_in;
	assign inq_out = cmd_inq_in && drv;
	// even parity over bits 31:5 only.
	always_comb begin
		bus_out = ~last_q[28:0];
		par_out = ~last_q[29];
		if (drv) bus_out[28:2] = cmd_addr_in[31:5];
		if (drv) par_out = ^cmd_addr_in[31:5] ^ cmd_bad_in;
		if (dev_hi_oe_in) bus_out[28:2] = dev_addr_in[28:2];
		if (dev_lo_oe_in) bus_out[1:0] = dev_addr_in[1:0];
		if (dev_par_oe_in) par_out = dev_par_in;
	end
	always_ff @(posedge clk_in) last_q <= {par_out, bus_out};
endmodule : cba_sys_model
`default_nettype wire

// ===== tb/tb_cba_addr_phase.sv
// Self-checking bench of the bus address-phase block.
`timescale 1ns/1ns
`default_nettype none
module tb_cba_addr_phase;
	import cba_pkg::*;
	logic clk_in, rst_b_in, mask, rv, rdy, hold, inq, hi_oe, lo_oe, par;
	logic c_hold, c_inq, bad, pbit, poe, stb, stbc, err_n;
	logic [28:0] bus, aout;
	logic [31:0] iaddr;
	cba_req_t req;
	cba_snoop_t snoop;
	int err_count, comparisons;
	cba_addr_phase cba_addr_phase_inst (.clk_in, .rst_b_in,
		.addr20_mask_in(mask), .req_valid_in(rv), .req_in(req),
		.req_ready_out(rdy), .addr_hold_req(hold), .inq_valid_in(inq),
		.addr_bus_in(bus), .addr_bus_out(aout), .addr_hi_oe_out(hi_oe),
		.addr_lo_oe_out(lo_oe), .addr_parity_in(par), .addr_parity_bit(pbit),
		.addr_parity_oe_out(poe), .cycle_strobe_n(stb),
		.cycle_strobe_copy_n(stbc), .addr_parity_err_n(err_n),
		.snoop_out(snoop));
	cba_sys_model cba_sys_model_inst (.clk_in, .cmd_hold_in(c_hold),
		.cmd_inq_in(c_inq), .cmd_addr_in(iaddr), .cmd_bad_in(bad),
		.dev_addr_in(aout), .dev_hi_oe_in(hi_oe), .dev_lo_oe_in(lo_oe),
		.dev_par_in(pbit), .dev_par_oe_in(poe), .hold_out(hold),
		.inq_out(inq), .bus_out(bus), .par_out(par));
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic do_req(cba_kind_t k, logic [31:0] a, logic m);
		logic [28:0] x;
		x = (k == CBA_KIND_SPECIAL) ? a[28:0] : a[31:3];
		if (m && k != CBA_KIND_SPECIAL) x[17] = 1'h0;
		@(posedge clk_in);
		rv <= 1'h1;
		mask <= m;
		req <= '{k, a, a[28:0]};
		@(negedge clk_in);
		while (rdy !== 1'h1) @(negedge clk_in);
		@(posedge clk_in);
		rv <= 1'h0;
		@(negedge clk_in);
		chk("addr", {3'h0, x}, {3'h0, aout});
		chk("parity", {31'h0, ^x[28:2]}, {31'h0, pbit});
		chk("strobes", 32'h0, {30'h0, stb, stbc});
		@(negedge clk_in);
		chk("strobes end", 32'h3, {30'h0, stb, stbc});
	endtask : do_req
	task automatic t_cycles;
		do_req(CBA_KIND_MEM, 32'hfff0_fff8, 1'h1);
		do_req(CBA_KIND_MEM, 32'hfff0_fff8, 1'h0);
		do_req(CBA_KIND_IO, 32'h0010_0cf8, 1'h1);
		do_req(CBA_KIND_SPECIAL, 32'h1fff_ffff, 1'h1);
	endtask : t_cycles
	task automatic t_inquire;
		@(posedge clk_in);
		c_hold <= 1'h1;
		@(posedge clk_in);
		@(negedge clk_in);
		chk("float", 32'h0, {28'h0, hi_oe, lo_oe, poe, rdy});
		chk("driven", 32'h3, {30'h0, stb, err_n});
		for (int b = 0; b < 2; b++) begin
			@(posedge clk_in);
			c_inq <= 1'h1;
			iaddr <= b ? 32'h7bde_f018 : 32'h8421_0ff8;
			bad <= b[0];
			@(posedge clk_in);
			c_inq <= 1'h0;
			@(negedge clk_in);
			chk("snoop", {iaddr[31:5], 5'h0}, snoop.addr);
			chk("check", {30'h0, 1'h1, !b[0]}, {30'h0, snoop.valid, err_n});
		end
		@(negedge clk_in);
		chk("err end", 32'h1, {31'h0, err_n});
		@(posedge clk_in);
		c_hold <= 1'h0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk("redrive", 32'h7, {29'h0, hi_oe, lo_oe, poe});
		do_req(CBA_KIND_MEM, 32'h0123_4568, 1'h0);
	endtask : t_inquire
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	initial begin
		clk_in = 1'h0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		{rst_b_in, mask, rv, c_hold, c_inq, bad} = '0;
		req = '0;
		iaddr = '0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		chk("reset", 32'h7, {29'h0, stb, err_n, hi_oe});
		@(posedge clk_in);
		rst_b_in <= 1'h1;
		t_cycles();
		t_inquire();
		results();
	end
	initial begin
		#20000;
		err_count++;
		results();
	end
endmodule : tb_cba_addr_phase
`default_nettype wire
